// ---- drr_router.sv ----
// dma request router: maps peripheral request flags onto 64 channel inputs
module drr_router (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [drr_pkg::NUM_ADC_FIFO-1:0] adc_cmd_fill,
    input wire logic [drr_pkg::NUM_ADC_FIFO-1:0] adc_rslt_drain,
    input wire logic [drr_pkg::NUM_SPI-1:0] spi_tx_fill,
    input wire logic [drr_pkg::NUM_SPI-1:0] spi_rx_drain,
    input wire logic sci_a_tdre,
    input wire logic sci_a_tc,
    input wire logic sci_a_lin_tx,
    input wire logic sci_a_rdrf,
    input wire logic sci_a_lin_rx,
    input wire logic [drr_pkg::NUM_TMR-1:0] tmr_flag,
    input wire logic [drr_pkg::NUM_TPU_CH-1:0] tpu_dtr,
    output logic [drr_pkg::NUM_CH-1:0] dma_req
);
    // one registered stage so outputs come from flops; no sticky hold, level follows source
    typedef struct packed {
        logic [drr_pkg::NUM_CH-1:0] req;
        // low for the first edge after reset, when $past still sees reset-time inputs
        logic armed;
    } drr_state_t;

    drr_state_t state_ff;
    drr_state_t nxt_state;
    logic [drr_pkg::NUM_TPU-1:0] tpu_sel;

    drr_tpu_sel u_tpu_sel (
        .tpu_dtr(tpu_dtr),
        .tpu_sel(tpu_sel)
    );

    always_comb
    begin
        nxt_state.req = drr_pkg::REQ_RESET;
        nxt_state.armed = 1'b1;
        for (int i = 0; i < drr_pkg::NUM_ADC_FIFO; i++)
        begin
            nxt_state.req[drr_pkg::CH_ADC_BASE + 2*i] = adc_cmd_fill[i];
            nxt_state.req[drr_pkg::CH_ADC_BASE + 2*i + 1] = adc_rslt_drain[i];
        end
        for (int i = 0; i < drr_pkg::NUM_SPI; i++)
        begin
            nxt_state.req[drr_pkg::CH_SPI_BASE + 2*i] = spi_tx_fill[i];
            nxt_state.req[drr_pkg::CH_SPI_BASE + 2*i + 1] = spi_rx_drain[i];
        end
        nxt_state.req[drr_pkg::CH_SCI_TX] = sci_a_tdre | sci_a_tc | sci_a_lin_tx;
        nxt_state.req[drr_pkg::CH_SCI_RX] = sci_a_rdrf | sci_a_lin_rx;
        for (int i = 0; i < drr_pkg::NUM_TMR_LO; i++)
        begin
            nxt_state.req[drr_pkg::CH_TMR_BASE + i] = tmr_flag[i];
        end
        nxt_state.req[drr_pkg::CH_TMR8] = tmr_flag[drr_pkg::TMR_IDX_8];
        nxt_state.req[drr_pkg::CH_TMR9] = tmr_flag[drr_pkg::TMR_IDX_9];
        for (int i = 0; i < drr_pkg::NUM_TPU; i++)
        begin
            nxt_state.req[drr_pkg::CH_TPU_BASE + i] = tpu_sel[i];
        end
    end

    // one cycle of delay; sources hold their level until serviced, so nothing is lost
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state_ff <= '{req: drr_pkg::REQ_RESET, armed: 1'b0};
        else
            state_ff <= nxt_state;
    end

    assign dma_req = state_ff.req;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_live;
        state_ff.armed;
    endsequence
    sequence s_tx_any;
        sci_a_tdre || sci_a_tc || sci_a_lin_tx;
    endsequence
    sequence s_rx_any;
        sci_a_rdrf || sci_a_lin_rx;
    endsequence
    sequence s_tx_none;
        !sci_a_tdre && !sci_a_tc && !sci_a_lin_tx;
    endsequence
    sequence s_rx_none;
        !sci_a_rdrf && !sci_a_lin_rx;
    endsequence

    a_adc_cmd_map: assert property (
        s_live |-> {dma_req[10], dma_req[8], dma_req[6], dma_req[4], dma_req[2], dma_req[0]}
        == $past(adc_cmd_fill)) else $error("adc command map wrong");

    a_adc_cmd_last: assert property (
        $rose(adc_cmd_fill[5]) |=> dma_req[10])
        else $error("adc command fifo 5 request missed");

    a_adc_rslt_map: assert property (
        s_live |-> {dma_req[11], dma_req[9], dma_req[7], dma_req[5], dma_req[3], dma_req[1]}
        == $past(adc_rslt_drain)) else $error("adc result map wrong");

    a_adc_rslt_odd: assert property (
        $rose(adc_rslt_drain[0]) |=> dma_req[1])
        else $error("adc result fifo 0 request missed");

    a_spi_tx_map: assert property (
        s_live |-> {dma_req[16], dma_req[14], dma_req[12]} == $past(spi_tx_fill))
        else $error("spi transmit map wrong");

    a_spi_b_tx: assert property (
        $rose(spi_tx_fill[0]) |=> dma_req[12])
        else $error("spi b transmit request missed");

    a_spi_c_tx: assert property (
        $rose(spi_tx_fill[1]) |=> dma_req[14])
        else $error("spi c transmit request missed");

    a_spi_rx_map: assert property (
        s_live |-> {dma_req[17], dma_req[15], dma_req[13]} == $past(spi_rx_drain))
        else $error("spi receive map wrong");

    a_spi_c_rx: assert property (
        $rose(spi_rx_drain[1]) |=> dma_req[15])
        else $error("spi c receive request missed");

    a_spi_d_rx: assert property (
        $rose(spi_rx_drain[2]) |=> dma_req[17])
        else $error("spi d receive request missed");

    a_sci_tx_or: assert property (
        s_tx_any |=> dma_req[18])
        else $error("sci transmit request missed");

    a_sci_idle_low: assert property (
        s_tx_none |=> !dma_req[18])
        else $error("sci transmit spurious");

    a_sci_lin_tx: assert property (
        $rose(sci_a_lin_tx) |=> dma_req[18])
        else $error("sci lin transmit request missed");

    a_sci_tx_exact: assert property (
        s_live |-> dma_req[18] == $past(sci_a_tdre | sci_a_tc | sci_a_lin_tx))
        else $error("sci transmit combine wrong");

    a_sci_rx_or: assert property (
        s_rx_any |=> dma_req[19])
        else $error("sci receive request missed");

    a_sci_rx_idle: assert property (
        s_rx_none |=> !dma_req[19])
        else $error("sci receive spurious");

    a_sci_rx_exact: assert property (
        s_live |-> dma_req[19] == $past(sci_a_rdrf | sci_a_lin_rx))
        else $error("sci receive combine wrong");

    a_tmr_map: assert property (
        s_live |-> dma_req[26:20] == {$past(tmr_flag[9]), $past(tmr_flag[8]),
        $past(tmr_flag[4:0])}) else $error("timer map wrong");

    a_tmr_zero: assert property (
        $rose(tmr_flag[0]) |=> dma_req[20])
        else $error("timer 0 request missed");

    a_tmr_skip: assert property (
        s_live |-> dma_req[25] == $past(tmr_flag[8]))
        else $error("timer 8 map wrong");

    a_tmr_nine: assert property (
        s_live |-> dma_req[26] == $past(tmr_flag[9]))
        else $error("timer 9 map wrong");

    a_tpu_map: assert property (
        s_live |-> dma_req[31:27] == {$past(tpu_dtr[15]), $past(tpu_dtr[14]),
        $past(tpu_dtr[2:0])}) else $error("tpu map wrong");

    a_tpu_low: assert property (
        s_live |-> dma_req[29:27] == $past(tpu_dtr[2:0]))
        else $error("tpu low channels wrong");

    a_tpu_fifteen: assert property (
        $rose(tpu_dtr[15]) |=> dma_req[31])
        else $error("tpu channel 15 request missed");

    a_unused_low: assert property (
        dma_req[63:32] == 32'h0000_0000)
        else $error("unassigned channel asserted");

    // checked through reset itself, so the default disable is overridden here
    a_reset_clear: assert property (
        disable iff (1'b0) rst |=> dma_req == drr_pkg::REQ_RESET)
        else $error("request survived reset");

    a_no_latch: assert property (
        $fell(adc_cmd_fill[0]) |=> !dma_req[0])
        else $error("request held after source dropped");

    a_no_stretch_rx: assert property (
        $fell(adc_rslt_drain[5]) |=> !dma_req[11])
        else $error("result request held after source dropped");

    a_no_stretch_tmr: assert property (
        $fell(tmr_flag[9]) |=> !dma_req[26])
        else $error("timer request held after source dropped");

    a_no_stretch_tpu: assert property (
        $fell(tpu_dtr[0]) |=> !dma_req[27])
        else $error("tpu request held after source dropped");
endmodule // drr_router

// ---- drr_pkg.sv ----
// package: channel map and widths for the dma request router
package drr_pkg;
    localparam int unsigned NUM_CH = 64;
    localparam int unsigned NUM_ADC_FIFO = 6;
    localparam int unsigned NUM_SPI = 3;
    localparam int unsigned NUM_TMR_LO = 5;
    localparam int unsigned NUM_TPU = 5;
    localparam int unsigned NUM_TMR = 10;
    localparam int unsigned NUM_TPU_CH = 16;
    localparam int unsigned CH_ADC_BASE = 0;
    localparam int unsigned CH_SPI_BASE = 12;
    localparam int unsigned CH_SCI_TX = 18;
    localparam int unsigned CH_SCI_RX = 19;
    localparam int unsigned CH_TMR_BASE = 20;
    localparam int unsigned CH_TMR8 = 25;
    localparam int unsigned CH_TMR9 = 26;
    localparam int unsigned CH_TPU_BASE = 27;
    localparam int unsigned TMR_IDX_8 = 8;
    localparam int unsigned TMR_IDX_9 = 9;
    localparam logic [63:0] REQ_RESET = 64'h0000_0000_0000_0000;
endpackage : drr_pkg

// ---- drr_tpu_sel.sv ----
// selects the five time processor unit channels that feed dma channels 27..31
module drr_tpu_sel (
    input wire logic [drr_pkg::NUM_TPU_CH-1:0] tpu_dtr,
    output logic [drr_pkg::NUM_TPU-1:0] tpu_sel
);
    // channels 0, 1, 2, 14, 15 only
    assign tpu_sel = {tpu_dtr[15], tpu_dtr[14], tpu_dtr[2], tpu_dtr[1], tpu_dtr[0]};
endmodule // drr_tpu_sel

// ---- drr_src_model.sv ----
// far side model: peripheral request flags held as plain levels
module drr_src_model (
    input wire logic [48:0] lvl,
    output logic [5:0] cmd,
    output logic [5:0] rslt,
    output logic [2:0] stx,
    output logic [2:0] srx,
    output logic [4:0] sci,
    output logic [9:0] tmr,
    output logic [15:0] tpu
);
    // flags stay up until the bench clears them, as a serviced source would
    assign {tpu, tmr, sci, srx, stx, rslt, cmd} = lvl;
endmodule // drr_src_model

// ---- tb_dma_request_router.sv ----
// self-checking testbench for the dma request router
module tb_dma_request_router;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [48:0] lvl = '1;
    logic [5:0] cf, rd;
    logic [2:0] st, sr;
    logic [4:0] sc;
    logic [9:0] tf;
    logic [15:0] tp;
    logic [63:0] req;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    initial forever #2 mclk = ~mclk;
    drr_src_model u_drr_src_model (.lvl(lvl), .cmd(cf), .rslt(rd), .stx(st), .srx(sr),
        .sci(sc), .tmr(tf), .tpu(tp));
    drr_router u_drr_router (.mclk(mclk), .rst(rst), .adc_cmd_fill(cf), .adc_rslt_drain(rd),
        .spi_tx_fill(st), .spi_rx_drain(sr), .sci_a_tdre(sc[0]), .sci_a_tc(sc[1]),
        .sci_a_lin_tx(sc[2]), .sci_a_rdrf(sc[3]), .sci_a_lin_rx(sc[4]), .tmr_flag(tf),
        .tpu_dtr(tp), .dma_req(req));
    // source bit b of lvl to the one channel it must raise, none for unused sources
    function automatic logic [63:0] exp_of(int b);
        int c;
        c = b < 6 ? 2*b : b < 12 ? 2*b-11 : b < 15 ? 2*b-12 : b < 18 ? 2*b-17
          : b < 21 ? 18 : b < 23 ? 19 : b < 28 ? b-3 : b < 31 ? -1 : b == 31 ? 25
          : b == 32 ? 26 : b < 36 ? b-6 : b > 46 ? b-17 : -1;
        return c < 0 ? 64'h0 : 64'h1 << c;
    endfunction
    task automatic chk(string n, logic [63:0] e);
        comparisons++;
        if (req !== e)
        begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, req);
        end
    endtask
    task automatic summarize();
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_all();
        @(posedge mclk) lvl <= '1;
        @(posedge mclk);
        @(negedge mclk) chk("all", 64'h0000_0000_ffff_ffff);
    endtask
    task automatic t_walk();
        for (int b = 0; b < 49; b++)
        begin
            @(posedge mclk) lvl <= 49'h1 << b;
            @(posedge mclk);
            @(negedge mclk) chk("map", exp_of(b));
        end
    endtask
    // one flop stage, no stretching: a level in gives the same level one cycle on
    task automatic t_hold();
        @(posedge mclk) lvl <= 49'h1;
        @(negedge mclk) chk("early", 64'h8000_0000);
        @(negedge mclk) chk("pass", 64'h1);
        @(posedge mclk) lvl <= 49'h0;
        @(negedge mclk) chk("held", 64'h1);
        @(negedge mclk) chk("drop", 64'h0);
    endtask
    // reset in mid-run clears every channel at once and the map returns after release
    task automatic t_rst();
        @(posedge mclk)
        begin
            lvl <= '1;
            rst <= 1'b1;
        end
        @(negedge mclk) chk("rst_on", 64'h0);
        @(posedge mclk) rst <= 1'b0;
        @(negedge mclk) chk("rst_off", 64'h0);
        @(negedge mclk) chk("rst_map", 64'h0000_0000_ffff_ffff);
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        repeat (19) @(posedge mclk);
        @(negedge mclk) chk("reset", 64'h0);
        @(posedge mclk) rst <= 1'b0;
        t_all();
        t_walk();
        t_hold();
        t_rst();
        summarize();
    end
endmodule // tb_dma_request_router
